// ### common/tws_pkg.sv
package tws_pkg;

    localparam int             CORE_PERIOD_NS = 10;
    localparam int             FLT_NS         = 100;
    localparam int             FLT_CYC        = (FLT_NS / CORE_PERIOD_NS < 1) ? 1 :
                                                FLT_NS / CORE_PERIOD_NS;
    localparam int             FLT_CNT_W      = 4;
    localparam logic [3:0]     FLT_LAST       = 4'(FLT_CYC - 1);

    localparam int             BYTE_W         = 8;
    localparam int             BIT_CNT_W      = 4;
    localparam logic [3:0]     BITS_PER_BYTE  = 4'h8;
    localparam int             MSB_POS        = 7;
    localparam int             RW_POS         = 0;
    localparam int             ID_HI_POS      = 7;
    localparam int             ID_LO_POS      = 4;
    // Device type code: the value is arbitrary.
    localparam logic [3:0]     DEV_TYPE_ID    = 4'h6;
    localparam logic [7:0]     IDLE_BYTE      = 8'hFF;

    localparam int             RX_W           = 9;
    localparam int             TX_W           = 8;
    localparam int             FIFO_DEPTH     = 8;

    localparam logic           LINE_RST       = 1'h1;
    localparam logic [3:0]     BIT_RST        = 4'h0;
    localparam logic [7:0]     SH_RST         = 8'h00;

    typedef enum logic [7:0] {
        ST_IDLE = 8'h01,
        ST_ADDR = 8'h02,
        ST_AACK = 8'h04,
        ST_WR   = 8'h08,
        ST_WACK = 8'h10,
        ST_RD   = 8'h20,
        ST_RACK = 8'h40,
        ST_WAIT = 8'h80
    } tws_state_t;

endpackage

// ### common/tws_strm_if.sv
`timescale 1ns/1ps
`default_nettype none
interface tws_strm_if #(parameter int W = 8);
    logic [W-1:0] data;
    logic         valid;
    logic         ready;
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface
`default_nettype wire

// ### rtl/tws_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module tws_fifo #(
    parameter int W     = 9,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Streams
    tws_strm_if.snk  wr,
    tws_strm_if.src  rd
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0]  mem_q [DEPTH];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] wp_d;
    logic [AW-1:0] rp_q;
    logic [AW-1:0] rp_d;
    logic [AW:0]   cnt_q;
    logic [AW:0]   cnt_d;
    logic          push;
    logic          pop;

    // Depth must be a power of two so the pointers wrap on their own.
    assign wr.ready = (cnt_q != (AW+1)'(DEPTH));
    assign rd.valid = (cnt_q != '0);
    assign rd.data  = mem_q[rp_q];
    assign push     = wr.valid && wr.ready;
    assign pop      = rd.valid && rd.ready;

    always_comb begin
        wp_d  = push ? wp_q + 1'b1 : wp_q;
        rp_d  = pop ? rp_q + 1'b1 : rp_q;
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = cnt_q + 1'b1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            wp_q  <= wp_d;
            rp_q  <= rp_d;
            cnt_q <= cnt_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_q[wp_q] <= wr.data;
        end
    end
endmodule
`default_nettype wire

// ### rtl/tws_hs.sv
`timescale 1ns/1ps
`default_nettype none
module tws_hs #(
    parameter int W = 8
) (
    // Source domain
    input wire logic clk_s,
    input wire logic rst_s,
    tws_strm_if.snk  in_s,
    // Destination domain
    input wire logic clk_d,
    input wire logic rst_d,
    tws_strm_if.src  out_d
);
    logic         free_q;
    logic         free_d;
    logic         req_q;
    logic         req_d;
    logic [W-1:0] hold_q;
    logic [W-1:0] hold_d;
    logic         ack_s1_q;
    logic         ack_s2_q;
    logic         req_s1_q;
    logic         req_s2_q;
    logic         ack_q;
    logic         ack_d;
    logic         val_q;
    logic         val_d;
    logic [W-1:0] dat_q;
    logic [W-1:0] dat_d;

    // The held word stays still until the acknowledge returns, so the far side
    // may copy it as a whole once the request toggle has been synchronised.
    assign in_s.ready = free_q;
    assign out_d.valid = val_q;
    assign out_d.data  = dat_q;

    always_comb begin
        free_d = free_q;
        req_d  = req_q;
        hold_d = hold_q;
        if (free_q && in_s.valid) begin
            hold_d = in_s.data;
            req_d  = !req_q;
            free_d = 1'b0;
        end else if (!free_q && ack_s2_q == req_q) begin
            free_d = 1'b1;
        end
    end

    always_ff @(posedge clk_s) begin
        if (rst_s) begin
            free_q   <= 1'b1;
            req_q    <= 1'b0;
            hold_q   <= '0;
            ack_s1_q <= 1'b0;
            ack_s2_q <= 1'b0;
        end else begin
            free_q   <= free_d;
            req_q    <= req_d;
            hold_q   <= hold_d;
            ack_s1_q <= ack_q;
            ack_s2_q <= ack_s1_q;
        end
    end

    always_comb begin
        val_d = val_q;
        dat_d = dat_q;
        ack_d = ack_q;
        if (!val_q && req_s2_q != ack_q) begin
            val_d = 1'b1;
            dat_d = hold_q;
        end else if (val_q && out_d.ready) begin
            val_d = 1'b0;
            ack_d = !ack_q;
        end
    end

    always_ff @(posedge clk_d) begin
        if (rst_d) begin
            req_s1_q <= 1'b0;
            req_s2_q <= 1'b0;
            ack_q    <= 1'b0;
            val_q    <= 1'b0;
            dat_q    <= '0;
        end else begin
            req_s1_q <= req_q;
            req_s2_q <= req_s1_q;
            ack_q    <= ack_d;
            val_q    <= val_d;
            dat_q    <= dat_d;
        end
    end
endmodule
`default_nettype wire

// ### rtl/tws_slave.sv
`timescale 1ns/1ps
`default_nettype none
module tws_slave
    import tws_pkg::*;
(
    // Clocks and reset
    input  wire logic              CORE_CLK_I,
    input  wire logic              LINK_CLK_I,
    input  wire logic              RST_I,
    // Two-wire bus
    input  wire logic              SCL_I,
    input  wire logic              SDA_I,
    output logic                   SDA_O,
    output logic                   SDA_OE_O,
    output logic                   BUS_BUSY_O,
    // Received bytes, link clock
    output logic [BYTE_W-1:0]      RX_DATA_O,
    output logic                   RX_FIRST_O,
    output logic                   RX_VALID_O,
    input  wire logic              RX_READY_I,
    // Bytes to send, link clock
    input  wire logic [BYTE_W-1:0] TX_DATA_I,
    input  wire logic              TX_VALID_I,
    output logic                   TX_READY_O,
    // Nonvolatile write start, link clock
    output logic                   NVW_START_O
);
    tws_strm_if #(.W(RX_W)) rx_wr ();
    tws_strm_if #(.W(RX_W)) rx_rd ();
    tws_strm_if #(.W(RX_W)) rx_out ();
    tws_strm_if #(.W(TX_W)) tx_in ();
    tws_strm_if #(.W(TX_W)) tx_out ();

    logic                 lrst1_q;
    logic                 lrst2_q;
    logic [1:0]           s1_q;
    logic [1:0]           s2_q;
    logic [1:0]           flt_q;
    logic [1:0]           flt_d;
    logic [FLT_CNT_W-1:0] fcnt_q [2];
    logic [FLT_CNT_W-1:0] fcnt_d [2];
    logic                 scl_p_q;
    logic                 sda_p_q;
    logic                 scl_f;
    logic                 sda_f;
    logic                 scl_rise;
    logic                 scl_fall;
    logic                 start;
    logic                 stop;
    tws_state_t           st_q;
    tws_state_t           st_d;
    logic [BIT_CNT_W-1:0] bit_q;
    logic [BIT_CNT_W-1:0] bit_d;
    logic [BYTE_W-1:0]    sh_q;
    logic [BYTE_W-1:0]    sh_d;
    logic                 oe_q;
    logic                 oe_d;
    logic                 sda_lvl_q;
    logic                 rd_q;
    logic                 rd_d;
    logic                 mack_q;
    logic                 mack_d;
    logic                 wrote_q;
    logic                 wrote_d;
    logic                 busy_q;
    logic                 busy_d;
    logic                 nv_tgl_q;
    logic                 nv_tgl_d;
    logic                 nv1_q;
    logic                 nv2_q;
    logic                 nv3_q;
    logic                 nvw_q;
    logic                 load;
    logic [BYTE_W-1:0]    tx_byte;

    // Line sampling: index 0 is the clock line, index 1 the data line.
    always_comb begin
        flt_d = flt_q;
        for (int i = 0; i < 2; i++) begin
            fcnt_d[i] = '0;
            if (s2_q[i] != flt_q[i]) begin
                if (fcnt_q[i] == FLT_LAST) begin
                    flt_d[i] = s2_q[i];
                end else begin
                    fcnt_d[i] = fcnt_q[i] + 1'b1;
                end
            end
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            s1_q      <= {2{LINE_RST}};
            s2_q      <= {2{LINE_RST}};
            flt_q     <= {2{LINE_RST}};
            fcnt_q[0] <= '0;
            fcnt_q[1] <= '0;
            scl_p_q   <= LINE_RST;
            sda_p_q   <= LINE_RST;
        end else begin
            s1_q      <= {SDA_I, SCL_I};
            s2_q      <= s1_q;
            flt_q     <= flt_d;
            fcnt_q[0] <= fcnt_d[0];
            fcnt_q[1] <= fcnt_d[1];
            scl_p_q   <= flt_q[0];
            sda_p_q   <= flt_q[1];
        end
    end

    assign scl_f    = flt_q[0];
    assign sda_f    = flt_q[1];
    assign scl_rise = scl_f && !scl_p_q;
    assign scl_fall = !scl_f && scl_p_q;
    assign start    = scl_f && scl_p_q && sda_p_q && !sda_f;
    assign stop     = scl_f && scl_p_q && !sda_p_q && sda_f;

    // With no byte offered the device sends all ones, which a master reads as idle data.
    assign tx_byte  = tx_out.valid ? tx_out.data : IDLE_BYTE;

    // The clock line is never driven; only the data line has an output enable.
    always_comb begin
        st_d         = st_q;
        bit_d        = bit_q;
        sh_d         = sh_q;
        oe_d         = oe_q;
        rd_d         = rd_q;
        mack_d       = mack_q;
        wrote_d      = wrote_q;
        busy_d       = busy_q;
        nv_tgl_d     = nv_tgl_q;
        load         = 1'b0;
        rx_wr.valid  = 1'b0;
        rx_wr.data   = {1'b0, sh_q};
        tx_out.ready = 1'b0;
        if (start) begin
            st_d    = ST_ADDR;
            bit_d   = BIT_RST;
            oe_d    = 1'b0;
            rd_d    = 1'b0;
            wrote_d = 1'b0;
            busy_d  = 1'b1;
        end else if (stop) begin
            if (!rd_q && wrote_q) begin
                nv_tgl_d = !nv_tgl_q;
            end
            st_d    = ST_IDLE;
            oe_d    = 1'b0;
            wrote_d = 1'b0;
            busy_d  = 1'b0;
        end else begin
            case (st_q)
                ST_ADDR: begin
                    if (scl_rise) begin
                        sh_d  = {sh_q[MSB_POS-1:0], sda_f};
                        bit_d = bit_q + 1'b1;
                    end else if (scl_fall && bit_q == BITS_PER_BYTE) begin
                        if (sh_q[ID_HI_POS:ID_LO_POS] == DEV_TYPE_ID && rx_wr.ready) begin
                            rx_wr.valid = 1'b1;
                            rx_wr.data  = {1'b1, sh_q};
                            rd_d        = sh_q[RW_POS];
                            oe_d        = 1'b1;
                            st_d        = ST_AACK;
                        end else begin
                            st_d = ST_WAIT;
                        end
                    end
                end
                ST_AACK: begin
                    if (scl_fall) begin
                        bit_d = BIT_RST;
                        if (rd_q) begin
                            load = 1'b1;
                        end else begin
                            oe_d = 1'b0;
                            st_d = ST_WR;
                        end
                    end
                end
                ST_WR: begin
                    if (scl_rise) begin
                        sh_d  = {sh_q[MSB_POS-1:0], sda_f};
                        bit_d = bit_q + 1'b1;
                    end else if (scl_fall && bit_q == BITS_PER_BYTE) begin
                        if (rx_wr.ready) begin
                            rx_wr.valid = 1'b1;
                            wrote_d     = 1'b1;
                            oe_d        = 1'b1;
                            st_d        = ST_WACK;
                        end else begin
                            st_d = ST_WAIT;
                        end
                    end
                end
                ST_WACK: begin
                    if (scl_fall) begin
                        oe_d  = 1'b0;
                        bit_d = BIT_RST;
                        st_d  = ST_WR;
                    end
                end
                ST_RD: begin
                    if (scl_rise) begin
                        bit_d = bit_q + 1'b1;
                    end else if (scl_fall) begin
                        if (bit_q == BITS_PER_BYTE) begin
                            oe_d = 1'b0;
                            st_d = ST_RACK;
                        end else begin
                            sh_d = {sh_q[MSB_POS-1:0], 1'b1};
                            oe_d = !sh_q[MSB_POS-1];
                        end
                    end
                end
                ST_RACK: begin
                    if (scl_rise) begin
                        mack_d = !sda_f;
                    end else if (scl_fall) begin
                        if (mack_q) begin
                            load = 1'b1;
                        end else begin
                            st_d = ST_WAIT;
                        end
                    end
                end
                ST_WAIT: begin
                    oe_d = 1'b0;
                end
                ST_IDLE: begin
                    oe_d = 1'b0;
                end
                default: begin
                    st_d = ST_IDLE;
                    oe_d = 1'b0;
                end
            endcase
        end
        if (load) begin
            bit_d        = BIT_RST;
            sh_d         = tx_byte;
            oe_d         = !tx_byte[MSB_POS];
            tx_out.ready = tx_out.valid;
            mack_d       = 1'b0;
            st_d         = ST_RD;
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            st_q      <= ST_IDLE;
            bit_q     <= BIT_RST;
            sh_q      <= SH_RST;
            oe_q      <= 1'b0;
            sda_lvl_q <= 1'b0;
            rd_q      <= 1'b0;
            mack_q    <= 1'b0;
            wrote_q   <= 1'b0;
            busy_q    <= 1'b0;
            nv_tgl_q  <= 1'b0;
        end else begin
            st_q      <= st_d;
            bit_q     <= bit_d;
            sh_q      <= sh_d;
            oe_q      <= oe_d;
            sda_lvl_q <= 1'b0;
            rd_q      <= rd_d;
            mack_q    <= mack_d;
            wrote_q   <= wrote_d;
            busy_q    <= busy_d;
            nv_tgl_q  <= nv_tgl_d;
        end
    end

    assign SDA_O      = sda_lvl_q;
    assign SDA_OE_O   = oe_q;
    assign BUS_BUSY_O = busy_q;

    // A full buffer cannot hold the bus clock, so the byte is refused on the bus instead.
    tws_fifo #(.W(RX_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
        .clk_i (CORE_CLK_I),
        .rst_i (RST_I),
        .wr    (rx_wr),
        .rd    (rx_rd)
    );

    tws_hs #(.W(RX_W)) u_rx_hs (
        .clk_s (CORE_CLK_I),
        .rst_s (RST_I),
        .in_s  (rx_rd),
        .clk_d (LINK_CLK_I),
        .rst_d (lrst2_q),
        .out_d (rx_out)
    );

    tws_hs #(.W(TX_W)) u_tx_hs (
        .clk_s (LINK_CLK_I),
        .rst_s (lrst2_q),
        .in_s  (tx_in),
        .clk_d (CORE_CLK_I),
        .rst_d (RST_I),
        .out_d (tx_out)
    );

    assign rx_out.ready = RX_READY_I;
    assign RX_DATA_O    = rx_out.data[BYTE_W-1:0];
    assign RX_FIRST_O   = rx_out.data[BYTE_W];
    assign RX_VALID_O   = rx_out.valid;
    assign tx_in.data   = TX_DATA_I;
    assign tx_in.valid  = TX_VALID_I;
    assign TX_READY_O   = tx_in.ready;

    always_ff @(posedge LINK_CLK_I) begin
        lrst1_q <= RST_I;
        lrst2_q <= lrst1_q;
        if (lrst2_q) begin
            nv1_q <= 1'b0;
            nv2_q <= 1'b0;
            nv3_q <= 1'b0;
            nvw_q <= 1'b0;
        end else begin
            nv1_q <= nv_tgl_q;
            nv2_q <= nv1_q;
            nv3_q <= nv2_q;
            nvw_q <= nv2_q ^ nv3_q;
        end
    end

    assign NVW_START_O = nvw_q;
endmodule
`default_nettype wire

// ### bench/tws_slave_chk.sv
`timescale 1ns/1ps
`default_nettype none
module tws_slave_chk
    import tws_pkg::*;
(
    // Clocks and reset
    input wire logic              CORE_CLK_I,
    input wire logic              LINK_CLK_I,
    input wire logic              RST_I,
    // Bus
    input wire logic              SCL_I,
    input wire logic              SDA_I,
    input wire logic              SDA_O,
    input wire logic              SDA_OE_O,
    input wire logic              BUS_BUSY_O,
    // Streams
    input wire logic [BYTE_W-1:0] RX_DATA_O,
    input wire logic              RX_FIRST_O,
    input wire logic              RX_VALID_O,
    input wire logic              RX_READY_I,
    input wire logic [BYTE_W-1:0] TX_DATA_I,
    input wire logic              TX_VALID_I,
    input wire logic              TX_READY_O,
    input wire logic              NVW_START_O
);
    idle_release_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
        !BUS_BUSY_O |-> !SDA_OE_O)
        else $error("data driven on idle bus");
    // The filter delays every edge, so a change must trail a clock low for a while.
    oe_scl_low_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
        $changed(SDA_OE_O) |-> !SCL_I && !$past(SCL_I, 10))
        else $error("data drive changed near high clock");
    start_seen_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
        $rose(BUS_BUSY_O) |-> SCL_I && !SDA_I)
        else $error("busy without start");
    stop_seen_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
        $fell(BUS_BUSY_O) |-> SCL_I && SDA_I)
        else $error("idle without stop");
    glitch_free_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
        $rose(BUS_BUSY_O) |-> !$past(SDA_I, 9) && $past(SCL_I, 9))
        else $error("start seen through short pulse");
    nvw_pulse_a: assert property (@(posedge LINK_CLK_I) disable iff (RST_I)
        NVW_START_O |=> !NVW_START_O)
        else $error("write start longer than one cycle");
    rx_hold_a: assert property (@(posedge LINK_CLK_I) disable iff (RST_I)
        RX_VALID_O && !RX_READY_I |=> RX_VALID_O && $stable(RX_DATA_O) && $stable(RX_FIRST_O))
        else $error("rx word dropped before taken");
    first_addr_a: assert property (@(posedge LINK_CLK_I) disable iff (RST_I)
        RX_VALID_O && RX_FIRST_O |-> RX_DATA_O[7:4] == DEV_TYPE_ID)
        else $error("first byte not an address");
endmodule

bind tws_slave tws_slave_chk i_chk (
    .CORE_CLK_I(CORE_CLK_I), .LINK_CLK_I(LINK_CLK_I), .RST_I(RST_I), .SCL_I(SCL_I),
    .SDA_I(SDA_I), .SDA_O(SDA_O), .SDA_OE_O(SDA_OE_O), .BUS_BUSY_O(BUS_BUSY_O),
    .RX_DATA_O(RX_DATA_O), .RX_FIRST_O(RX_FIRST_O), .RX_VALID_O(RX_VALID_O),
    .RX_READY_I(RX_READY_I), .TX_DATA_I(TX_DATA_I), .TX_VALID_I(TX_VALID_I),
    .TX_READY_O(TX_READY_O), .NVW_START_O(NVW_START_O)
);
`default_nettype wire

// ### bench/tws_bus_mdl.sv
`timescale 1ns/1ps
`default_nettype none
module tws_bus_mdl (
    // Clock and resolved data line
    input  wire logic clk_i,
    input  wire logic sda_i,
    // Master drive
    output logic      scl_o,
    output logic      sda_pull_o
);
    initial begin
        scl_o      = 1'b1;
        sda_pull_o = 1'b0;
    end

    task automatic wait_cyc(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    // Only entered from a released bus, so both lines are high.
    task automatic start_c();
        wait_cyc(40);
        sda_pull_o = 1'b1;
        wait_cyc(40);
        scl_o = 1'b0;
        wait_cyc(20);
    endtask

    // Data moves well after the clock falls, so the filter never sees a false start.
    task automatic bit_c(input logic b, output logic r);
        sda_pull_o = ~b;
        wait_cyc(40);
        scl_o = 1'b1;
        wait_cyc(40);
        r = sda_i;
        scl_o = 1'b0;
        wait_cyc(20);
    endtask

    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_c(b[i], r);
        bit_c(1'b1, r);
        ack = ~r;
    endtask

    task automatic get_byte(input logic last, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_c(1'b1, r);
            b[i] = r;
        end
        bit_c(last, r);
    endtask

    task automatic stop_c();
        sda_pull_o = 1'b1;
        wait_cyc(40);
        scl_o = 1'b1;
        wait_cyc(40);
        sda_pull_o = 1'b0;
        wait_cyc(60);
    endtask

    task automatic glitch_c(input int n);
        sda_pull_o = 1'b1;
        wait_cyc(n);
        sda_pull_o = 1'b0;
        wait_cyc(60);
    endtask
endmodule
`default_nettype wire

// ### bench/tb_tws_slave.sv
`timescale 1ns/1ps
`default_nettype none
module tb_tws_slave;
    import tws_pkg::*;
    logic       clk;
    logic       lclk;
    logic       rst        = 1'b1;
    logic       scl;
    logic       m_pull;
    logic       sda_oe;
    logic       sda_o;
    logic       rx_take;
    logic       busy;
    logic       busy_seen  = 1'b0;
    logic [7:0] rx_data;
    logic       rx_first;
    logic       rx_valid;
    logic       rx_ready   = 1'b0;
    logic       rx_en      = 1'b1;
    logic [7:0] tx_data    = 8'h00;
    logic       tx_valid   = 1'b0;
    logic       tx_ready;
    logic       nvw;
    logic       ack;
    logic [7:0] b;
    logic [7:0] tx1;
    logic [7:0] tx3;
    int         n;
    int         nvw_n      = 0;
    int         n_mismatch = 0;
    int         tests_run  = 0;
    integer     seed       = 55591;
    logic [8:0] exp_q[$];
    wire logic  sda_w      = (m_pull | (sda_oe & ~sda_o)) ? 1'b0 : 1'b1;

    tws_slave i_dut (.CORE_CLK_I(clk), .LINK_CLK_I(lclk), .RST_I(rst), .SCL_I(scl),
        .SDA_I(sda_w), .SDA_O(sda_o), .SDA_OE_O(sda_oe), .BUS_BUSY_O(busy), .RX_DATA_O(rx_data),
        .RX_FIRST_O(rx_first), .RX_VALID_O(rx_valid), .RX_READY_I(rx_ready),
        .TX_DATA_I(tx_data), .TX_VALID_I(tx_valid), .TX_READY_O(tx_ready), .NVW_START_O(nvw));
    tws_bus_mdl i_mst (.clk_i(clk), .sda_i(sda_w), .scl_o(scl), .sda_pull_o(m_pull));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        lclk = 1'b0;
        #2.3;
        forever #6 lclk = ~lclk;
    end

    task automatic check(input logic [8:0] got, input logic [8:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // A refused byte never reaches the link, so its expectation is withdrawn.
    task automatic send(input logic first, input logic [7:0] d);
        exp_q.push_back({first, d});
        i_mst.put_byte(d, ack);
        if (ack !== 1'b1) void'(exp_q.pop_back());
    endtask

    task automatic tx_put(input logic [7:0] d);
        @(negedge lclk);
        for (int i = 0; i < 50 && tx_ready !== 1'b1; i++) @(negedge lclk);
        check(9'(tx_ready), 9'h001, "tx ready");
        tx_data  = d;
        tx_valid = 1'b1;
        @(negedge lclk);
        tx_valid = 1'b0;
        for (int i = 0; i < 50 && tx_ready !== 1'b1; i++) @(negedge lclk);
    endtask

    // The word is taken at the next rising edge if ready is offered now, so check it here.
    always @(negedge lclk) begin
        rx_take = rx_en && ($random(seed) % 2 != 0);
        if (rx_valid === 1'b1 && rx_take)
            check({rx_first, rx_data}, exp_q.size() ? exp_q.pop_front() : 9'h1FF, "rx");
        if (nvw === 1'b1) nvw_n++;
        rx_ready <= rx_take;
    end
    always @(negedge clk) if (busy === 1'b1) busy_seen <= 1'b1;

    initial begin
        repeat (20) @(negedge clk);
        rst = 1'b0;
        repeat (100) @(negedge clk);
        i_mst.glitch_c(5);
        check(9'(busy_seen), 9'h000, "glitch");
        i_mst.start_c();
        send(1'b1, 8'h6C);
        check(9'(ack), 9'h001, "addr ack");
        for (int i = 0; i < 3; i++) begin
            send(1'b0, 8'($random(seed)));
            check(9'(ack), 9'h001, "wr ack");
        end
        i_mst.stop_c();
        repeat (200) @(negedge clk);
        check(9'(nvw_n), 9'h001, "nv start");
        check(9'(busy_seen && !busy), 9'h001, "busy");
        $display("write test done");
        tx1 = 8'($random(seed));
        tx3 = 8'($random(seed)) & 8'h7F;
        tx_put(tx1);
        i_mst.start_c();
        send(1'b1, 8'h6D);
        i_mst.get_byte(1'b0, b);
        check(9'(b), 9'(tx1), "rd1");
        tx_put(tx3);
        i_mst.get_byte(1'b0, b);
        check(9'(b), 9'h0FF, "rd2");
        i_mst.wait_cyc(20);
        tx_put(8'h00);
        i_mst.get_byte(1'b1, b);
        check(9'(b), 9'(tx3), "rd3");
        i_mst.wait_cyc(10);
        check(9'(sda_oe), 9'h000, "nack release");
        i_mst.stop_c();
        $display("read test done");
        i_mst.start_c();
        send(1'b1, 8'h5C);
        check(9'(ack), 9'h000, "foreign addr");
        i_mst.stop_c();
        rx_en = 1'b0;
        repeat (4) @(negedge lclk);
        i_mst.start_c();
        send(1'b1, 8'h6C);
        n = 0;
        while (ack === 1'b1 && n < 14) begin
            n++;
            send(1'b0, 8'($random(seed)));
        end
        check(9'(n >= FIFO_DEPTH && ack === 1'b0), 9'h001, "fill");
        i_mst.stop_c();
        rx_en = 1'b1;
        repeat (600) @(negedge clk);
        check(9'(exp_q.size()), 9'h000, "drain");
        check(9'(nvw_n), 9'h002, "nv start 2");
        $display("fill test done");
        results();
    end

    initial begin
        repeat (90000) @(posedge clk);
        n_mismatch++;
        $display("BAD %0t watchdog", $time);
        results();
    end
endmodule
`default_nettype wire
